/* src/fcp_pkg.sv */
// Constants, field layout and types for the fuse configuration programmer
package fcp_pkg;

  // Clock and timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int ZAP_TIME_NS  = 5000;
  localparam int ZAP_CYC      = ZAP_TIME_NS / (1_000_000_000 / CLK_HZ);
  localparam int STARTUP_CYC  = 8;
  localparam int ZAP_CNT_W    = 9;
  localparam int START_CNT_W  = 4;

  // Configuration stream layout
  localparam int STREAM_BITS  = 52;
  localparam int IDX_W        = 6;
  localparam int PARAM_BITS   = 42;
  localparam int SET_W        = 14;
  localparam int SET1_LSB     = 0;
  localparam int SET2_LSB     = 14;
  localparam int SET3_LSB     = 28;
  localparam int OFF_LSB      = 0;
  localparam int OFF_W        = 8;
  localparam int CFG_LSB      = 8;
  localparam int CFG_W        = 4;
  localparam int MSK_LSB      = 12;
  localparam int MSK_W        = 2;
  localparam int CFG_RANGE_LSB = 0;
  localparam int CFG_DIR_BIT  = 2;
  localparam int CFG_SPAN_BIT = 3;
  localparam int MSK_MAG_BIT  = 0;
  localparam int MSK_DIG_BIT  = 1;

  // Synchronised pin positions
  localparam int PIN_N        = 4;
  localparam int PIN_VPP      = 0;
  localparam int PIN_BURN     = 1;
  localparam int PIN_SDI      = 2;
  localparam int PIN_SCK      = 3;

  // Register map (byte addresses)
  localparam int ADDR_W       = 8;
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_SETTING   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;
  localparam logic [7:0] ADDR_STREAM_LO = 8'h14;
  localparam logic [7:0] ADDR_STREAM_HI = 8'h18;

  localparam int CTRL_BURN_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BLOW_BIT = 2;
  localparam int STAT_IDX_LSB  = 8;

  localparam int IRQ_W        = 3;
  localparam int IRQ_BIT      = 0;
  localparam int IRQ_BLOWN    = 1;
  localparam int IRQ_DONE     = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FCP_ST_START,
    FCP_ST_NORMAL,
    FCP_ST_TRIAL,
    FCP_ST_BURN
  } fcp_mode_t;

endpackage

/* src/fcp_pin_sync.sv */
// Two-stage synchroniser with rising-edge detection for the programming pins
`timescale 1ns/1ps
module fcp_pin_sync
  import fcp_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Pins from outside the clock domain
  input  wire logic [PIN_N-1:0] i_pins,
  // Synchronised view
  output logic      [PIN_N-1:0] o_level,
  output logic      [PIN_N-1:0] o_rise
);

  logic [PIN_N-1:0] meta_q;
  logic [PIN_N-1:0] sync_q;
  logic [PIN_N-1:0] prev_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= i_pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;

endmodule

/* src/fcp_fuse_config_programmer.sv */
// Fuse configuration programmer: mode entry, stream shift, fuse burn and settings
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module fcp_fuse_config_programmer
  import fcp_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]      i_s_axi_awaddr,
  input  wire logic                   i_s_axi_awvalid,
  output logic                        o_s_axi_awready,
  input  wire logic [31:0]            i_s_axi_wdata,
  input  wire logic [3:0]             i_s_axi_wstrb,
  input  wire logic                   i_s_axi_wvalid,
  output logic                        o_s_axi_wready,
  output logic [1:0]                  o_s_axi_bresp,
  output logic                        o_s_axi_bvalid,
  input  wire logic                   i_s_axi_bready,
  input  wire logic [ADDR_W-1:0]      i_s_axi_araddr,
  input  wire logic                   i_s_axi_arvalid,
  output logic                        o_s_axi_arready,
  output logic [31:0]                 o_s_axi_rdata,
  output logic [1:0]                  o_s_axi_rresp,
  output logic                        o_s_axi_rvalid,
  input  wire logic                   i_s_axi_rready,
  // Programming pins
  input  wire logic                   i_fuse_program_voltage_pin,
  input  wire logic                   i_fuse_burn_level,
  input  wire logic                   i_serial_chain_input,
  input  wire logic                   i_serial_clock_input,
  output logic                        o_error_indicator_output_n,
  // Fuse array
  input  wire logic [STREAM_BITS-1:0] i_fuse_sense,
  output logic                        o_fuse_blow,
  output logic [IDX_W-1:0]            o_fuse_addr,
  // Sensor side
  input  wire logic [OFF_W-1:0]       i_raw_position,
  input  wire logic                   i_digital_err,
  input  wire logic                   i_magnet_loss,
  output logic [OFF_W-1:0]            o_position,
  // Active setting
  output logic [OFF_W-1:0]            o_offset,
  output logic                        o_counter_clockwise,
  output logic [1:0]                  o_range_sel,
  output logic                        o_span_narrow,
  output logic                        o_err_digital_en,
  output logic                        o_err_magnet_en,
  // Interrupt
  output logic                        o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [SET_W-1:0] xor_sets(input logic [PARAM_BITS-1:0] s);
    xor_sets = s[SET1_LSB +: SET_W] ^ s[SET2_LSB +: SET_W] ^ s[SET3_LSB +: SET_W];
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    strb_merge = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;

  fcp_pin_sync u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pins  ({i_serial_clock_input, i_serial_chain_input,
               i_fuse_burn_level, i_fuse_program_voltage_pin}),
    .o_level (pin_lvl),
    .o_rise  (pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode entry at start-up

  fcp_mode_t              mode_q;
  logic [START_CNT_W-1:0] start_cnt_q;

  // Pins settle through the synchroniser before the mode is decided
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q      <= FCP_ST_START;
      start_cnt_q <= '0;
    end else if (mode_q == FCP_ST_START) begin
      start_cnt_q <= start_cnt_q + 1'b1;
      if (start_cnt_q == START_CNT_W'(STARTUP_CYC - 1)) begin
        if (pin_lvl[PIN_VPP] && !pin_lvl[PIN_SDI]) begin
          mode_q <= pin_lvl[PIN_BURN] ? FCP_ST_BURN : FCP_ST_TRIAL;
        end else begin
          mode_q <= FCP_ST_NORMAL;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stream shift and fuse burn

  logic                   prog_mode;
  logic                   shift_ev;
  logic [STREAM_BITS-1:0] image_q;
  logic [IDX_W-1:0]       idx_q;
  logic [IDX_W-1:0]       addr_q;
  logic [ZAP_CNT_W-1:0]   zap_cnt_q;
  logic                   blow_q;
  logic                   blow_done;
  logic                   stream_done;
  logic [31:0]            ctrl_q;

  assign prog_mode   = (mode_q == FCP_ST_TRIAL) || (mode_q == FCP_ST_BURN);
  assign shift_ev    = prog_mode && pin_rise[PIN_SCK] && (idx_q < IDX_W'(STREAM_BITS));
  assign stream_done = shift_ev && (idx_q == IDX_W'(STREAM_BITS - 1));
  assign blow_done   = blow_q && (zap_cnt_q == ZAP_CNT_W'(1));

  // Volatile image: lost on reset, never written to the fuses in trial mode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      image_q <= '0;
      idx_q   <= '0;
      addr_q  <= '0;
    end else if (shift_ev) begin
      image_q[idx_q] <= pin_lvl[PIN_SDI];
      addr_q         <= idx_q;
      idx_q          <= idx_q + 1'b1;
    end
  end

  // A new edge carrying a set bit restarts the pulse; programmer must pace edges to the burn time
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      blow_q    <= 1'b0;
      zap_cnt_q <= '0;
    end else if (shift_ev && (mode_q == FCP_ST_BURN) && pin_lvl[PIN_SDI]
                 && ctrl_q[CTRL_BURN_EN]) begin
      blow_q    <= 1'b1;
      zap_cnt_q <= ZAP_CNT_W'(ZAP_CYC);
    end else if (blow_q) begin
      zap_cnt_q <= zap_cnt_q - 1'b1;
      blow_q    <= !blow_done;
    end
  end

  assign o_fuse_blow = blow_q;
  assign o_fuse_addr = addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Active setting, position and error pin

  logic [SET_W-1:0] eff_q;
  logic [OFF_W-1:0] pos_q;
  logic             err_n_q;
  logic [PARAM_BITS-1:0] src;

  // Trial mode runs from the volatile image, otherwise from the fuses
  assign src = (mode_q == FCP_ST_TRIAL) ? image_q[PARAM_BITS-1:0]
                                        : i_fuse_sense[PARAM_BITS-1:0];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      eff_q <= '0;
    end else begin
      eff_q <= xor_sets(src);
    end
  end

  assign o_offset            = eff_q[OFF_LSB +: OFF_W];
  assign o_counter_clockwise = eff_q[CFG_LSB + CFG_DIR_BIT];
  assign o_range_sel         = eff_q[CFG_LSB + CFG_RANGE_LSB +: 2];
  assign o_span_narrow       = eff_q[CFG_LSB + CFG_SPAN_BIT];
  assign o_err_digital_en    = eff_q[MSK_LSB + MSK_DIG_BIT];
  assign o_err_magnet_en     = eff_q[MSK_LSB + MSK_MAG_BIT];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_q <= '0;
    end else if (o_counter_clockwise) begin
      pos_q <= o_offset - i_raw_position;
    end else begin
      pos_q <= i_raw_position - o_offset;
    end
  end

  assign o_position = pos_q;

  // In trial and fuse-burn modes low on the pin reads back a set bit of the last addressed position; in normal mode low flags an enabled error
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err_n_q <= 1'b1;
    end else if (mode_q == FCP_ST_BURN) begin
      err_n_q <= !i_fuse_sense[addr_q];
    end else if (mode_q == FCP_ST_TRIAL) begin
      err_n_q <= !image_q[addr_q];
    end else begin
      err_n_q <= !((o_err_digital_en && i_digital_err) ||
                   (o_err_magnet_en && i_magnet_loss));
    end
  end

  assign o_error_indicator_output_n = err_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and registers

  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              do_wr;
  logic [31:0]       mask_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_ev;
  logic [IRQ_W-1:0]  irq_clr;
  logic              irq_q;

  assign do_wr = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        awaddr_q  <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q  <= i_s_axi_wdata;
        wstrb_q  <= i_s_axi_wstrb;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_IRQ_STAT ||
                     awaddr_q == ADDR_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q  <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
    end else if (do_wr) begin
      if (awaddr_q == ADDR_CTRL) begin
        ctrl_q <= strb_merge(ctrl_q, wdata_q, wstrb_q);
      end
      if (awaddr_q == ADDR_IRQ_MASK) begin
        mask_q <= strb_merge(mask_q, wdata_q, wstrb_q);
      end
    end
  end

  // Event in the clearing cycle survives the clear
  assign irq_ev  = {stream_done, blow_done, shift_ev};
  assign irq_clr = (do_wr && awaddr_q == ADDR_IRQ_STAT && wstrb_q[0]) ?
                   wdata_q[IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      irq_q      <= |(irq_stat_q & mask_q[IRQ_W-1:0]);
    end
  end

  assign o_irq = irq_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (i_s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= RESP_OKAY;
      unique case (i_s_axi_araddr)
        ADDR_CTRL:      rdata_q <= ctrl_q;
        ADDR_STATUS:    rdata_q <= 32'(mode_q) | (32'(blow_q) << STAT_BLOW_BIT)
                                   | (32'(idx_q) << STAT_IDX_LSB);
        ADDR_SETTING:   rdata_q <= 32'(eff_q);
        ADDR_IRQ_STAT:  rdata_q <= 32'(irq_stat_q);
        ADDR_IRQ_MASK:  rdata_q <= mask_q;
        ADDR_STREAM_LO: rdata_q <= image_q[31:0];
        ADDR_STREAM_HI: rdata_q <= 32'(image_q[STREAM_BITS-1:32]);
        default: begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;

endmodule

/* sim/fcp_prog_model.sv */
// Behavioural programming controller driving serial clock and chain input
`timescale 1ns/1ps
module fcp_prog_model
  import fcp_pkg::*;
(
  // Control from the bench
  input  wire logic                   i_start,
  input  wire logic                   i_go,
  input  wire logic [STREAM_BITS-1:0] i_bits,
  input  wire logic [IDX_W-1:0]       i_count,
  input  wire logic                   i_slow,
  // Link to the device
  output logic                        o_sck,
  output logic                        o_sdi,
  output logic                        o_busy
);
  int k;
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_busy = 1'b0;
  end
  // Chain input low through start-up selects programming mode
  always @(posedge i_start) o_sdi = 1'b0;
  // LSB first at 160 ns a bit; clock idles low between bits
  always @(posedge i_go) begin
    o_busy = 1'b1;
    #7;
    for (k = 0; k < i_count; k++) begin
      o_sdi = i_bits[k];
      #40 o_sck = 1'b1;
      #80 o_sck = 1'b0;
      #40;
      // Slow pacing outlasts a whole burn pulse
      if (i_slow) #5200;
    end
    // Released line must not keep showing the last bit
    o_sdi = ~o_sdi;
    o_busy = 1'b0;
  end
endmodule

/* sim/fcp_fuse_config_programmer_monitor.sv */
// Port-level assertions for the fuse configuration programmer
`timescale 1ns/1ps
module fcp_monitor
  import fcp_pkg::*;
(
  // Clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  // Pins and fuse array
  input wire logic                   i_fuse_program_voltage_pin,
  input wire logic                   i_fuse_burn_level,
  input wire logic [STREAM_BITS-1:0] i_fuse_sense,
  input wire logic                   o_fuse_blow,
  // Sensor and setting
  input wire logic [OFF_W-1:0]       i_raw_position,
  input wire logic [OFF_W-1:0]       o_position,
  input wire logic [OFF_W-1:0]       o_offset,
  input wire logic                   o_counter_clockwise,
  input wire logic [1:0]             o_range_sel,
  input wire logic                   o_span_narrow,
  input wire logic                   o_err_digital_en,
  input wire logic                   o_err_magnet_en,
  // Read channel
  input wire logic                   i_s_axi_arvalid,
  input wire logic                   o_s_axi_arready,
  input wire logic                   o_s_axi_rvalid,
  input wire logic [31:0]            o_s_axi_rdata,
  input wire logic                   i_s_axi_rready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic [13:0] x_set;
  logic        fuse_src;
  assign x_set = i_fuse_sense[13:0] ^ i_fuse_sense[27:14] ^ i_fuse_sense[41:28];
  // Trial mode runs from the volatile image instead
  assign fuse_src = !i_fuse_program_voltage_pin || i_fuse_burn_level;
  sequence s_steady;
    !$past(i_rst) && fuse_src && $stable(i_fuse_sense);
  endsequence
  sequence s_rd_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  off_xor_a: assert property (s_steady |-> o_offset == x_set[7:0])
    else $error("offset not xor of sets");
  cfg_decode_a: assert property (s_steady |->
    {o_span_narrow, o_counter_clockwise, o_range_sel} == x_set[11:8])
    else $error("configuration decode wrong");
  mask_decode_a: assert property (s_steady |->
    {o_err_digital_en, o_err_magnet_en} == x_set[13:12])
    else $error("error mask decode wrong");
  pos_rel_a: assert property (!$past(i_rst) && $stable(o_offset) &&
    $stable(o_counter_clockwise) |-> o_position == ($past(o_counter_clockwise) ?
    $past(o_offset) - $past(i_raw_position) : $past(i_raw_position) - $past(o_offset)))
    else $error("position not relative to offset");
  blow_mode_a: assert property (o_fuse_blow |-> fuse_src && i_fuse_program_voltage_pin)
    else $error("burn outside fuse-burn mode");
  blow_len_a: assert property ($rose(o_fuse_blow) |-> o_fuse_blow [*8])
    else $error("burn pulse cut short");
  rd_answer_a: assert property (s_rd_take |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
endmodule
bind fcp_fuse_config_programmer fcp_monitor u_mon (
  .i_clk, .i_rst, .i_fuse_program_voltage_pin, .i_fuse_burn_level, .i_fuse_sense,
  .o_fuse_blow, .i_raw_position, .o_position, .o_offset, .o_counter_clockwise,
  .o_range_sel, .o_span_narrow, .o_err_digital_en, .o_err_magnet_en,
  .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid, .o_s_axi_rdata, .i_s_axi_rready
);

/* sim/fcp_fuse_config_programmer_tb.sv */
// Self-checking bench for the fuse configuration programmer
`timescale 1ns/1ps
module fcp_fuse_config_programmer_tb
  import fcp_pkg::*;
();
  logic i_clk, i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
  logic i_s_axi_rready, i_fuse_program_voltage_pin, i_fuse_burn_level, i_digital_err;
  logic i_magnet_loss, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_error_indicator_output_n, o_fuse_blow, o_irq, o_counter_clockwise;
  logic o_span_narrow, o_err_digital_en, o_err_magnet_en, go, slow, busy;
  logic i_serial_chain_input, i_serial_clock_input;
  logic [7:0]             i_s_axi_awaddr, i_s_axi_araddr, i_raw_position, o_position, o_offset;
  logic [31:0]            i_s_axi_wdata, o_s_axi_rdata;
  logic [3:0]             i_s_axi_wstrb;
  logic [1:0]             o_s_axi_bresp, o_s_axi_rresp, o_range_sel;
  logic [STREAM_BITS-1:0] i_fuse_sense, bits, v, keep;
  logic [IDX_W-1:0]       o_fuse_addr, cnt;
  logic [13:0]            setting, tgt;
  int                     n_errors, compares, seed;
  fcp_fuse_config_programmer uut (
    .i_clk, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
    .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
    .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
    .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_fuse_program_voltage_pin,
    .i_fuse_burn_level, .i_serial_chain_input, .i_serial_clock_input,
    .o_error_indicator_output_n, .i_fuse_sense, .o_fuse_blow, .o_fuse_addr,
    .i_raw_position, .i_digital_err, .i_magnet_loss, .o_position, .o_offset,
    .o_counter_clockwise, .o_range_sel, .o_span_narrow, .o_err_digital_en,
    .o_err_magnet_en, .o_irq
  );
  fcp_prog_model u_prog (
    .i_start(i_rst), .i_go(go), .i_bits(bits), .i_count(cnt), .i_slow(slow),
    .o_sck(i_serial_clock_input), .o_sdi(i_serial_chain_input), .o_busy(busy)
  );
  assign setting = {o_err_digital_en, o_err_magnet_en, o_span_narrow, o_counter_clockwise,
                    o_range_sel, o_offset};
  always #10 i_clk = ~i_clk;
  // Fuse array: a burn pulse makes the addressed bit read as blown
  always @(posedge i_clk)
    if (o_fuse_blow) i_fuse_sense[o_fuse_addr] <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] xor_sets(input logic [STREAM_BITS-1:0] s);
    return s[13:0] ^ s[27:14] ^ s[41:28];
  endfunction
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_araddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= wr;
    i_s_axi_wvalid <= wr;
    i_s_axi_bready <= wr;
    i_s_axi_arvalid <= !wr;
    i_s_axi_rready <= !wr;
    do begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      n++;
    end while (!(wr ? o_s_axi_bvalid : o_s_axi_rvalid));
    i_s_axi_bready <= 1'b0;
    i_s_axi_rready <= 1'b0;
    check("bus answer", 64'h0, 64'(n >= 40));
    check("response", resp, wr ? o_s_axi_bresp : o_s_axi_rresp);
    if (!wr) check("read data", d, o_s_axi_rdata);
  endtask
  task automatic restart(input logic vpp, input logic burn);
    i_rst <= 1'b1;
    i_fuse_program_voltage_pin <= vpp;
    i_fuse_burn_level <= burn;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask
  task automatic shift(input logic [STREAM_BITS-1:0] s, input logic [5:0] n, input logic sl);
    bits <= s;
    cnt <= n;
    slow <= sl;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    // Only the watchdog ends a stuck frame
    do begin
      @(posedge i_clk);
    end while (busy);
    // Last bit needs a few cycles to land in image and pin
    repeat (6) @(posedge i_clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    n_errors++;
    $display("unexpected run length: expected end, seen timeout");
    wrap_up();
  end
  initial begin
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_raw_position, i_fuse_sense} = '0;
    {i_digital_err, i_magnet_loss, go, slow, bits, cnt, n_errors, compares} = '0;
    {i_clk, i_rst, i_fuse_program_voltage_pin, i_fuse_burn_level} = 4'h4;
    i_s_axi_wstrb = 4'hf;
    seed = 21991;
    restart(1'b0, 1'b0);
    axi(1'b0, ADDR_CTRL, CTRL_RESET, RESP_OKAY);
    axi(1'b0, ADDR_IRQ_MASK, MASK_RESET, RESP_OKAY);
    axi(1'b0, 8'h1c, 32'h0, RESP_SLVERR);
    axi(1'b1, ADDR_STATUS, 32'h0, RESP_SLVERR);
    axi(1'b0, ADDR_STATUS, 32'h1, RESP_OKAY);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      i_fuse_sense <= STREAM_BITS'({$random(seed), $random(seed)});
      i_raw_position <= 8'($random(seed));
      {i_digital_err, i_magnet_loss} <= 2'($random(seed));
      repeat (3) @(posedge i_clk);
      tgt = xor_sets(i_fuse_sense);
      check("fuse setting", tgt, setting);
      check("position", 8'(tgt[10] ? tgt[7:0] - i_raw_position : i_raw_position - tgt[7:0]),
            o_position);
      check("error pin", !(tgt[13] && i_digital_err || tgt[12] && i_magnet_loss),
            o_error_indicator_output_n);
    end
    $display("normal mode test done");
    for (int c = 0; c < 8; c++) begin
      restart(1'b1, 1'b0);
      keep = i_fuse_sense;
      v = STREAM_BITS'({$random(seed), $random(seed)});
      tgt = {c[1:0], c[0], c[2:0], 8'($random(seed))};
      v[41:28] = v[41:28] ^ xor_sets(v) ^ tgt;
      axi(1'b1, ADDR_IRQ_MASK, {31'h0, c[0]}, RESP_OKAY);
      shift(v, 6'd42, 1'b0);
      check("trial setting", tgt, setting);
      check("readback pin", !v[41], o_error_indicator_output_n);
      check("fuse array", keep, i_fuse_sense);
      check("irq", c[0], o_irq);
      axi(1'b0, ADDR_STREAM_LO, v[31:0], RESP_OKAY);
      axi(1'b0, ADDR_STATUS, 32'h2a02, RESP_OKAY);
      axi(1'b1, ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
      repeat (2) @(posedge i_clk);
      check("irq cleared", 1'b0, o_irq);
      axi(1'b0, ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
    end
    $display("trial mode test done");
    restart(1'b1, 1'b1);
    i_fuse_sense <= '0;
    v = STREAM_BITS'({$random(seed), $random(seed)});
    shift(v, 6'd42, 1'b1);
    check("blown fuses", v[41:0], i_fuse_sense);
    check("burn setting", xor_sets(v), setting);
    check("readback pin", !v[41], o_error_indicator_output_n);
    axi(1'b0, ADDR_STREAM_LO, v[31:0], RESP_OKAY);
    axi(1'b1, ADDR_CTRL, 32'h0, RESP_OKAY);
    shift({STREAM_BITS{1'b1}}, 6'd4, 1'b1);
    check("burn disabled", v[41:0], i_fuse_sense);
    $display("fuse-burn test done");
    wrap_up();
  end
endmodule
